// ---- pbs_pkg.sv ----
// How it works
// - Loaded read data drives bus two clocks later
// - Controller drives write data two cycles later
// - Advance steps counter, ignores address, read/write and chip selects
// - Read load allowed during fourth read beat
// - Inactive clock enable freezes pipeline and data outputs; output enable still gates the pins
// - Latency counts enabled clocks only
// - Any command order, no turnaround cycle
// - Byte selects held valid each write advance
// - Write load allowed during fourth write beat
// - Deselect starts nothing, bus floats two later
// - Select needs a low, b_n low, b high
// - Burst order interleaved or linear, wraps
`default_nettype none
package pbs_pkg;
    localparam int ADDR_W_DEF  = 18;
    localparam int LANES_DEF   = 4;
    localparam int LANE_W_DEF  = 9;
    localparam int PIPE_DEPTH  = 2;
    localparam int BURST_LEN   = 4;
    localparam logic [1:0] BURST_ONE  = 2'h1;
    localparam logic [1:0] BURST_LAST = 2'h3;

    // Command codes held by the host between its user side and the link.
    typedef enum logic [1:0]
    {
        PBS_CMD_IDLE  = 2'h0,
        PBS_CMD_READ  = 2'h1,
        PBS_CMD_WRITE = 2'h3,
        PBS_CMD_BURST = 2'h2
    } pbs_cmd_t;

    // Next burst offset from the start offset and the beat count.
    function automatic logic [1:0] pbs_burst_step(input logic [1:0] start,
                                                  input logic [1:0] beat,
                                                  input logic       ilv);
        logic [1:0] res;
        res = ilv ? (start ^ beat) : 2'(start + beat);
        return res;
    endfunction
endpackage
`default_nettype wire

// ---- pbs_if.sv ----
`default_nettype none
interface pbs_if
#(
    parameter int ADDR_W = 18,
    parameter int LANES  = 4,
    parameter int LANE_W = 9
);
    logic [ADDR_W-1:0]       address;
    logic                    read_write;
    logic                    advance_or_load;
    logic                    chip_select_a_n;
    logic                    chip_select_b_n;
    logic                    chip_select_b;
    logic                    clock_enable_n;
    logic [LANES-1:0]        byte_lane_write_n;
    logic                    burst_order_select;
    logic                    output_enable_n;
    logic [LANES*LANE_W-1:0] dq_from_mem;
    logic                    dq_mem_oe_n;
    logic [LANES*LANE_W-1:0] dq_from_ctl;
    logic                    dq_ctl_oe_n;

    modport mem
    (
        input  address, read_write, advance_or_load, chip_select_a_n,
               chip_select_b_n, chip_select_b, clock_enable_n,
               byte_lane_write_n, burst_order_select, output_enable_n,
               dq_from_ctl, dq_ctl_oe_n,
        output dq_from_mem, dq_mem_oe_n
    );
    modport ctl
    (
        output address, read_write, advance_or_load, chip_select_a_n,
               chip_select_b_n, chip_select_b, clock_enable_n,
               byte_lane_write_n, burst_order_select, output_enable_n,
               dq_from_ctl, dq_ctl_oe_n,
        input  dq_from_mem, dq_mem_oe_n
    );
endinterface
`default_nettype wire

// ---- pbs_mem.sv ----
`default_nettype none
module pbs_mem
    import pbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF
)
(
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    pbs_if.mem        bus,
    output logic      busy_o
);
    localparam int DW = LANES * LANE_W;
    localparam int WORDS = 1 << ADDR_W;

    logic [DW-1:0]     mem_array [WORDS];
    logic              en;
    logic              sel;
    logic [ADDR_W-1:0] base_reg;
    logic [1:0]        beat_reg;
    logic              burst_rd_reg;
    logic              burst_live_reg;
    logic [ADDR_W-1:0] cur_addr;
    logic              cur_valid;
    logic              cur_rd;
    logic [ADDR_W-1:0] p_addr_reg [PIPE_DEPTH];
    logic              p_valid_reg [PIPE_DEPTH];
    logic              p_rd_reg [PIPE_DEPTH];
    logic [LANES-1:0]  p_bw_reg [PIPE_DEPTH];
    logic [DW-1:0]     q_reg;
    logic              q_drive_reg;

    assign en  = !bus.clock_enable_n;
    // Any false enable deselects the part.
    assign sel = !bus.chip_select_a_n && !bus.chip_select_b_n
                 && bus.chip_select_b;

    ////////////////////////////////////////////////////////////////////////
    // Address stage: load, advance or deselect.
    always_comb
    begin
        cur_valid = 1'b0;
        cur_rd    = 1'b0;
        cur_addr  = bus.address;
        if (!bus.advance_or_load)
        begin
            cur_valid = sel;
            cur_rd    = bus.read_write;
        end
        else
        begin
            cur_valid = burst_live_reg;
            cur_rd    = burst_rd_reg;
            cur_addr  = {base_reg[ADDR_W-1:2],
                         pbs_burst_step(base_reg[1:0], beat_reg,
                                        bus.burst_order_select)};
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            base_reg       <= '0;
            beat_reg       <= 2'h0;
            burst_rd_reg   <= 1'b0;
            burst_live_reg <= 1'b0;
        end
        else if (en)
        begin
            if (!bus.advance_or_load)
            begin
                base_reg       <= bus.address;
                beat_reg       <= BURST_ONE;
                burst_rd_reg   <= bus.read_write;
                burst_live_reg <= sel;
            end
            else
            begin
                // Wraps after the fourth beat and keeps counting.
                beat_reg <= 2'(beat_reg + BURST_ONE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-stage pipeline, frozen while clock enable is inactive.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                p_addr_reg[i]  <= '0;
                p_valid_reg[i] <= 1'b0;
                p_rd_reg[i]    <= 1'b0;
                p_bw_reg[i]    <= '1;
            end
        end
        else if (en)
        begin
            p_addr_reg[0]  <= cur_addr;
            p_valid_reg[0] <= cur_valid;
            p_rd_reg[0]    <= cur_rd;
            p_bw_reg[0]    <= bus.byte_lane_write_n;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                p_addr_reg[i]  <= p_addr_reg[i-1];
                p_valid_reg[i] <= p_valid_reg[i-1];
                p_rd_reg[i]    <= p_rd_reg[i-1];
                p_bw_reg[i]    <= p_bw_reg[i-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data stage. Reads fetch on the second enabled edge so the word
    // stands on the bus for the whole data cycle; writes capture the bus
    // on the edge that closes the data cycle.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q_reg       <= '0;
            q_drive_reg <= 1'b0;
        end
        else if (en)
        begin
            q_drive_reg <= p_valid_reg[0] && p_rd_reg[0];
            if (p_valid_reg[0] && p_rd_reg[0])
            begin
                q_reg <= mem_array[p_addr_reg[0]];
            end
        end
    end

    // Memory array has no reset; contents are undefined at power-up.
    always_ff @(posedge core_clk_i)
    begin
        if (en && p_valid_reg[PIPE_DEPTH-1] && !p_rd_reg[PIPE_DEPTH-1])
        begin
            for (int l = 0; l < LANES; l++)
            begin
                if (!p_bw_reg[PIPE_DEPTH-1][l])
                begin
                    mem_array[p_addr_reg[PIPE_DEPTH-1]][l*LANE_W +: LANE_W]
                        <= bus.dq_from_ctl[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign bus.dq_from_mem = q_reg;
    // Output enable gates the pins only, never the pipeline.
    assign bus.dq_mem_oe_n = !(q_drive_reg && !bus.output_enable_n);
    assign busy_o = p_valid_reg[0] || p_valid_reg[PIPE_DEPTH-1];
endmodule
`default_nettype wire

// ---- pbs_ctl.sv ----
`default_nettype none
module pbs_ctl
    import pbs_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF
)
(
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_b_i,
    pbs_if.ctl                           bus,
    input  wire logic [1:0]              cmd_i,
    input  wire logic [ADDR_W-1:0]       addr_i,
    input  wire logic [LANES*LANE_W-1:0] wdata_i,
    input  wire logic [LANES-1:0]        lane_en_i,
    input  wire logic                    stall_i,
    input  wire logic                    interleave_i,
    input  wire logic                    out_en_i,
    output logic [LANES*LANE_W-1:0]      rdata_o,
    output logic                         rvalid_o
);
    localparam int DW = LANES * LANE_W;

    logic [DW-1:0]    wd_reg [PIPE_DEPTH];
    logic             wv_reg [PIPE_DEPTH];
    logic             rv_reg [PIPE_DEPTH];
    logic             burst_wr_reg;
    logic             burst_live_reg;
    logic [LANES-1:0] burst_bw_reg;
    logic             is_load;
    logic             is_wr;

    assign is_load = (cmd_i == PBS_CMD_READ) || (cmd_i == PBS_CMD_WRITE);
    // A beat after a deselect moves nothing, so it must not be mirrored.
    assign is_wr   = (cmd_i == PBS_CMD_WRITE) ||
                     ((cmd_i == PBS_CMD_BURST) && burst_wr_reg
                      && burst_live_reg);

    // Commands go straight to the pins; any order is legal.
    assign bus.address            = addr_i;
    assign bus.read_write         = (cmd_i != PBS_CMD_WRITE);
    assign bus.advance_or_load    = (cmd_i == PBS_CMD_BURST);
    assign bus.chip_select_a_n    = !(is_load || (cmd_i == PBS_CMD_BURST));
    assign bus.chip_select_b_n    = bus.chip_select_a_n;
    assign bus.chip_select_b      = !bus.chip_select_a_n;
    assign bus.clock_enable_n     = stall_i;
    // Burst beats reuse the lane mask of their load.
    assign bus.byte_lane_write_n  = (cmd_i == PBS_CMD_BURST) ?
                                    burst_bw_reg : ~lane_en_i;
    assign bus.burst_order_select = interleave_i;
    assign bus.output_enable_n    = !out_en_i;

    ////////////////////////////////////////////////////////////////////////
    // Mirrors the device pipeline in enabled clocks.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            burst_wr_reg   <= 1'b0;
            burst_live_reg <= 1'b0;
            burst_bw_reg   <= '1;
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                wd_reg[i] <= '0;
                wv_reg[i] <= 1'b0;
                rv_reg[i] <= 1'b0;
            end
        end
        else if (!stall_i)
        begin
            if (is_load)
            begin
                burst_wr_reg <= (cmd_i == PBS_CMD_WRITE);
                burst_bw_reg <= ~lane_en_i;
            end
            if (cmd_i != PBS_CMD_BURST)
            begin
                burst_live_reg <= is_load;
            end
            wd_reg[0] <= wdata_i;
            wv_reg[0] <= is_wr;
            rv_reg[0] <= (cmd_i == PBS_CMD_READ) ||
                         ((cmd_i == PBS_CMD_BURST) && !burst_wr_reg
                          && burst_live_reg);
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                wd_reg[i] <= wd_reg[i-1];
                wv_reg[i] <= wv_reg[i-1];
                rv_reg[i] <= rv_reg[i-1];
            end
        end
    end

    // Write data leave two enabled cycles after their command.
    assign bus.dq_from_ctl = wd_reg[PIPE_DEPTH-1];
    assign bus.dq_ctl_oe_n = !wv_reg[PIPE_DEPTH-1];

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o  <= '0;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= !stall_i && rv_reg[PIPE_DEPTH-1];
            if (!stall_i && rv_reg[PIPE_DEPTH-1])
            begin
                rdata_o <= bus.dq_from_mem;
            end
        end
    end
endmodule
`default_nettype wire

// ---- pbs_chk.sv ----
`default_nettype none
module pbs_chk
#(
    parameter int LANES  = 4,
    parameter int LANE_W = 9
)
(
    input wire logic                    core_clk_i,
    input wire logic                    rst_b_i,
    input wire logic                    read_write,
    input wire logic                    advance_or_load,
    input wire logic                    chip_select_a_n,
    input wire logic                    chip_select_b_n,
    input wire logic                    chip_select_b,
    input wire logic                    clock_enable_n,
    input wire logic                    output_enable_n,
    input wire logic [LANES*LANE_W-1:0] dq_from_mem,
    input wire logic                    dq_mem_oe_n,
    input wire logic                    dq_ctl_oe_n
);
    wire logic sel = !chip_select_a_n && !chip_select_b_n && chip_select_b;
    wire logic ld  = !advance_or_load && sel && !clock_enable_n;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////////////
    a_read_lat: assert property (ld && read_write ##1 !clock_enable_n
        ##1 !output_enable_n |-> !dq_mem_oe_n)
        else $error("read data missing two cycles after load");
    a_burst_beat: assert property (ld && read_write
        ##1 advance_or_load && !clock_enable_n ##1 !clock_enable_n
        ##1 !output_enable_n |-> !dq_mem_oe_n)
        else $error("burst beat missing on bus");
    a_write_lat: assert property (ld && !read_write
        ##1 !clock_enable_n |=> !dq_ctl_oe_n && dq_mem_oe_n)
        else $error("write data not on bus two cycles after load");
    a_no_clash: assert property (dq_mem_oe_n || dq_ctl_oe_n)
        else $error("both ends drive the data bus");
    a_desel_float: assert property (!advance_or_load && !sel
        && !clock_enable_n ##1 !clock_enable_n
        |=> dq_mem_oe_n && dq_ctl_oe_n)
        else $error("bus driven two cycles after deselect");
    // Output enable is asynchronous, so a change beside a stall is allowed.
    a_stall_hold: assert property (clock_enable_n
        |=> $stable(dq_ctl_oe_n) && (!$stable(output_enable_n)
        || $stable(dq_mem_oe_n) && (dq_mem_oe_n || $stable(dq_from_mem))))
        else $error("bus changed on a suspended edge");
    a_oe_float: assert property (output_enable_n |-> dq_mem_oe_n)
        else $error("memory drives with output enable off");
    a_sel_code: assert property (!advance_or_load && !clock_enable_n
        |-> chip_select_a_n == chip_select_b_n
        && chip_select_b == !chip_select_a_n)
        else $error("chip selects not driven together");
    c_read: cover property (ld && read_write);
    c_stall: cover property (!dq_mem_oe_n && clock_enable_n);
    c_turn: cover property (!dq_mem_oe_n ##1 !dq_ctl_oe_n);
endmodule
`default_nettype wire

// ---- pipelined_burst_sram_cycles_tb.sv ----
`default_nettype none
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            n_fail++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end
module pipelined_burst_sram_cycles_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;
    localparam int DW = 36;
    // Rows: command, address, flags (bit 1 interleave, bit 0 stall) and
    // the row number whose write data a read should return (0 for none).
    typedef struct packed
    {
        logic [3:0] cmd;
        logic [7:0] adr;
        logic [1:0] pad;
        logic       il;
        logic       st;
        logic [3:0] src;
    } pbs_row_t;
    pbs_row_t rows [24] = '{20'h3_0500, 20'h2_0000, 20'h2_0000, 20'h2_0000,
        20'h3_0a00, 20'h1_0501, 20'h2_0002, 20'h2_0003, 20'h2_0004,
        20'h2_0001, 20'h1_0a05, 20'h3_0b00, 20'h1_0a05, 20'h1_0b10,
        20'h0_0010, 20'h1_0b0c, 20'h1_0622, 20'h2_0030, 20'h2_0023,
        20'h2_0024, 20'h0_0000, 20'h2_0000, 20'h2_0000, 20'h0_0000};
    logic          core_clk_i   = 1'h0;
    logic          rst_b_i      = 1'h0;
    logic [1:0]    cmd_i        = 2'h0;
    logic [AW-1:0] addr_i       = 6'h00;
    logic [DW-1:0] wdata_i      = 36'h0_0000_0000;
    logic [3:0]    lane_en_i    = 4'hf;
    logic          stall_i      = 1'h0;
    logic          interleave_i = 1'h0;
    logic          out_en_i     = 1'h1;
    logic          chk_on       = 1'h1;
    logic [DW-1:0] rdata_o;
    logic          rvalid_o;
    logic [DW-1:0] e;
    logic [DW-1:0] exp_q [$];
    int            n_fail       = 0;
    int            comparisons  = 0;
    ////////////////////////////////////////////////////////////////////////
    pbs_if #(.ADDR_W(AW)) bus_if ();
    pbs_mem #(.ADDR_W(AW)) pbs_mem_i (.core_clk_i, .rst_b_i, .bus(bus_if),
        .busy_o());
    pbs_ctl #(.ADDR_W(AW)) pbs_ctl_i (.core_clk_i, .rst_b_i, .bus(bus_if),
        .cmd_i, .addr_i, .wdata_i, .lane_en_i, .stall_i, .interleave_i,
        .out_en_i, .rdata_o, .rvalid_o);
    pbs_chk pbs_chk_i (.core_clk_i, .rst_b_i,
        .read_write(bus_if.read_write),
        .advance_or_load(bus_if.advance_or_load),
        .chip_select_a_n(bus_if.chip_select_a_n),
        .chip_select_b_n(bus_if.chip_select_b_n),
        .chip_select_b(bus_if.chip_select_b),
        .clock_enable_n(bus_if.clock_enable_n),
        .output_enable_n(bus_if.output_enable_n),
        .dq_from_mem(bus_if.dq_from_mem), .dq_mem_oe_n(bus_if.dq_mem_oe_n),
        .dq_ctl_oe_n(bus_if.dq_ctl_oe_n));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [DW-1:0] pat(input logic [4:0] k);
        return 36'h1_1111_1111 * DW'(k);
    endfunction
    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        forever #50 core_clk_i = !core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        if (chk_on && rvalid_o === 1'h1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            `CHK(rdata_o, e)
        end
    end
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge core_clk_i);
            cmd_i        <= rows[i].cmd[1:0];
            addr_i       <= rows[i].adr[AW-1:0];
            wdata_i      <= pat(5'(i + 1));
            interleave_i <= rows[i].il;
            stall_i      <= rows[i].st;
            if (rows[i].src != 4'h0)
                exp_q.push_back(pat({1'h0, rows[i].src}));
            #1;
            if (rows[i].cmd == 4'h1 && !rows[i].st)
                `CHK({bus_if.chip_select_a_n, bus_if.chip_select_b_n,
                      bus_if.chip_select_b, bus_if.read_write}, 4'h3)
        end
        // A read whose output enable drops in its data cycle is not scored.
        @(posedge core_clk_i);
        chk_on <= 1'h0;
        cmd_i  <= 2'h1;
        @(posedge core_clk_i);
        cmd_i  <= 2'h0;
        @(posedge core_clk_i);
        out_en_i <= 1'h0;
        #1 `CHK(bus_if.dq_mem_oe_n, 1'h1)
        @(posedge core_clk_i);
        out_en_i <= 1'h1;
        cmd_i    <= 2'h1;
        @(posedge core_clk_i);
        cmd_i   <= 2'h0;
        rst_b_i <= 1'h0;
        #1 `CHK({rvalid_o, bus_if.dq_mem_oe_n, bus_if.dq_ctl_oe_n}, 3'h3)
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        chk_on  <= 1'h1;
        // The burst beat to word 9 must reuse the lane 0 mask of its load.
        @(posedge core_clk_i);
        cmd_i   <= 2'h3;
        addr_i  <= 6'h09;
        wdata_i <= pat(5'h03);
        @(posedge core_clk_i);
        addr_i    <= 6'h08;
        lane_en_i <= 4'h1;
        @(posedge core_clk_i);
        cmd_i     <= 2'h2;
        lane_en_i <= 4'hf;
        wdata_i   <= pat(5'h05);
        @(posedge core_clk_i);
        cmd_i <= 2'h0;
        repeat (2) @(posedge core_clk_i);
        cmd_i  <= 2'h1;
        addr_i <= 6'h09;
        exp_q.push_back(36'h3_3333_3355);
        @(posedge core_clk_i);
        cmd_i  <= 2'h1;
        addr_i <= 6'h05;
        exp_q.push_back(pat(5'h01));
        @(posedge core_clk_i);
        cmd_i <= 2'h0;
        for (int k = 0; k < 20 && exp_q.size() != 0; k++)
            @(posedge core_clk_i);
        `CHK(exp_q.size(), 0)
        end_sim();
    end
endmodule
`undef CHK
`default_nettype wire
